/* File: xae_cfg.svh */
`ifndef XAE_CFG_SVH
`define XAE_CFG_SVH

// SFR addresses of the pointer and extension registers
`define XAE_SFR_PTR0_LO 8'h82
`define XAE_SFR_PTR0_HI 8'h83
`define XAE_SFR_PTR1_LO 8'h84
`define XAE_SFR_PTR1_HI 8'h85
`define XAE_SFR_PTR_SEL 8'h86
`define XAE_SFR_PTR0_EXT 8'h93
`define XAE_SFR_PTR1_EXT 8'h95
`define XAE_SFR_IDX_UPPER 8'hEA
`define XAE_SFR_IDX_MIDDLE 8'hA0

// Fast port SFR addresses, one byte per port, in port order
// 0, 1, 2, 3, 4, 5, 6, 12, 15
`define XAE_PORT_COUNT 9
`define XAE_SFR_DATA_MAP 72'hF8_E8D8_C8C0_B098_9080
`define XAE_SFR_STATE_MAP 72'hF9_E9D9_C9C1_B199_9189
`define XAE_SFR_SEL_MAP 72'hFA_F2DA_CAC2_B29A_A28A

// Field positions
`define XAE_PTR_SEL_BIT 0

// Reset values
`define XAE_RST_BYTE 8'h00
`define XAE_RST_PTR 16'h0000
`define XAE_RST_ADDR 24'h00_0000

// External-data region bounds, inclusive
`define XAE_SRAM_LO 24'h00_0000
`define XAE_SRAM_HI 24'h00_1FFF
`define XAE_IOPORT_LO 24'h00_5000
`define XAE_IOPORT_HI 24'h00_51FF
`define XAE_EMIFCTL_LO 24'h00_5400
`define XAE_EMIFCTL_HI 24'h00_54FF
`define XAE_HUBCFG_LO 24'h00_7000
`define XAE_HUBCFG_HI 24'h00_7FFF
`define XAE_NVDATA_LO 24'h00_8000
`define XAE_NVDATA_HI 24'h00_8FFF
`define XAE_INTERCON_LO 24'h01_0000
`define XAE_INTERCON_HI 24'h01_FFFF
`define XAE_ECC_LO 24'h08_0000
`define XAE_ECC_HI 24'h08_1FFF
`define XAE_OFFCHIP_LO 24'h80_0000

`endif

/* File: xae_pkg.sv */
`default_nettype none
package xae_pkg;
  typedef enum logic [3:0] {
    XAE_REG_NONE = 4'h0,
    XAE_REG_SRAM = 4'h1,
    XAE_REG_IOPORT = 4'h2,
    XAE_REG_EMIFCTL = 4'h3,
    XAE_REG_HUBCFG = 4'h4,
    XAE_REG_NVDATA = 4'h5,
    XAE_REG_INTERCON = 4'h6,
    XAE_REG_ECC = 4'h7,
    XAE_REG_OFFCHIP = 4'h8,
    XAE_REG_OTHER = 4'h9
  } xae_region_type;
  typedef logic [7:0] xae_byte_type;
endpackage : xae_pkg
`default_nettype wire

/* File: xae_fast_port.sv */
`include "xae_cfg.svh"
`default_nettype none
module xae_fast_port (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_data,
  input wire logic wr_sel,
  input wire xae_pkg::xae_byte_type wdata,
  input wire xae_pkg::xae_byte_type hub_port_output_data,
  input wire xae_pkg::xae_byte_type pin_level,
  output xae_pkg::xae_byte_type data_q,
  output xae_pkg::xae_byte_type sel_q,
  output xae_pkg::xae_byte_type state_q,
  output xae_pkg::xae_byte_type pin_out_q
);
  import xae_pkg::*;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      data_q <= `XAE_RST_BYTE;
    else if (wr_data)
      data_q <= wdata;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      sel_q <= `XAE_RST_BYTE;
    else if (wr_sel)
      sel_q <= wdata;
  end

  // No write path: the pin-state byte only follows the pins
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state_q <= `XAE_RST_BYTE;
    else
      state_q <= pin_level;
  end

  // Per-pin choice between the fast path and the hub register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pin_out_q <= `XAE_RST_BYTE;
    else
      pin_out_q <= (sel_q & data_q) | (~sel_q & hub_port_output_data);
  end
endmodule : xae_fast_port
`default_nettype wire

/* File: xae_sfr_ext.sv */
`include "xae_cfg.svh"
`default_nettype none
module xae_sfr_ext (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire xae_pkg::xae_byte_type sfr_wdata,
  output xae_pkg::xae_byte_type sfr_rdata_q,
  output logic sfr_hit_q,
  input wire logic ptr_inc,
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_value,
  output logic [15:0] active_pointer_q,
  input wire logic xmove_req,
  input wire logic xmove_via_index,
  input wire xae_pkg::xae_byte_type xmove_index,
  output logic [23:0] xdata_addr_q,
  output xae_pkg::xae_region_type xdata_region_q,
  output logic xdata_valid_q,
  input wire logic [71:0] hub_port_output_data,
  input wire logic [71:0] pin_level,
  output logic [71:0] port_pin_out_q
);
  import xae_pkg::*;

  localparam int NP = `XAE_PORT_COUNT;
  localparam logic [71:0] DATA_MAP = `XAE_SFR_DATA_MAP;
  localparam logic [71:0] STATE_MAP = `XAE_SFR_STATE_MAP;
  localparam logic [71:0] SEL_MAP = `XAE_SFR_SEL_MAP;

  logic [15:0] first_data_pointer_q;
  logic [15:0] second_data_pointer_q;
  logic pointer_select_q;
  xae_byte_type first_pointer_extension_q;
  xae_byte_type second_pointer_extension_q;
  xae_byte_type index_upper_extension_q;
  xae_byte_type index_middle_extension_q;
  logic [NP-1:0] port_wr_data;
  logic [NP-1:0] port_wr_sel;
  logic [71:0] port_data;
  logic [71:0] port_sel;
  logic [71:0] port_state;
  logic [15:0] active_pointer_d;
  logic [23:0] xdata_addr_d;
  xae_byte_type rdata_d;
  logic hit_d;
  logic sel_wr;
  logic ptr0_lo_wr;
  logic ptr0_hi_wr;
  logic ptr1_lo_wr;
  logic ptr1_hi_wr;
  logic ext0_wr;
  logic ext1_wr;
  logic idx_upper_wr;
  logic idx_middle_wr;

  function automatic xae_region_type region_of(input logic [23:0] a);
    xae_region_type r;
    r = XAE_REG_OTHER;
    if (a >= `XAE_OFFCHIP_LO)
      r = XAE_REG_OFFCHIP;
    else if (a <= `XAE_SRAM_HI)
      r = XAE_REG_SRAM;
    else if (a >= `XAE_ECC_LO && a <= `XAE_ECC_HI)
      r = XAE_REG_ECC;
    else if (a >= `XAE_NVDATA_LO && a <= `XAE_NVDATA_HI)
      r = XAE_REG_NVDATA;
    else if (a >= `XAE_IOPORT_LO && a <= `XAE_IOPORT_HI)
      r = XAE_REG_IOPORT;
    else if (a >= `XAE_INTERCON_LO && a <= `XAE_INTERCON_HI)
      r = XAE_REG_INTERCON;
    else if (a >= `XAE_HUBCFG_LO && a <= `XAE_HUBCFG_HI)
      r = XAE_REG_HUBCFG;
    else if (a >= `XAE_EMIFCTL_LO && a <= `XAE_EMIFCTL_HI)
      r = XAE_REG_EMIFCTL;
    return r;
  endfunction : region_of

  // Port strobes from the address maps
  always_comb
  begin
    for (int i = 0; i < NP; i++)
    begin
      port_wr_data[i] = sfr_wr_en && (sfr_addr == DATA_MAP[i*8 +: 8]);
      port_wr_sel[i] = sfr_wr_en && (sfr_addr == SEL_MAP[i*8 +: 8]);
    end
  end

  // Decoded once so every core register block shares one compare
  always_comb
  begin
    sel_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR_SEL);
    ptr0_lo_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR0_LO);
    ptr0_hi_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR0_HI);
    ptr1_lo_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR1_LO);
    ptr1_hi_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR1_HI);
    ext0_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR0_EXT);
    ext1_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_PTR1_EXT);
    idx_upper_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_IDX_UPPER);
    idx_middle_wr = sfr_wr_en && (sfr_addr == `XAE_SFR_IDX_MIDDLE);
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : gen_port
      xae_fast_port u_port (
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_data(port_wr_data[g]),
        .wr_sel(port_wr_sel[g]),
        .wdata(sfr_wdata),
        .hub_port_output_data(hub_port_output_data[g*8 +: 8]),
        .pin_level(pin_level[g*8 +: 8]),
        .data_q(port_data[g*8 +: 8]),
        .sel_q(port_sel[g*8 +: 8]),
        .state_q(port_state[g*8 +: 8]),
        .pin_out_q(port_pin_out_q[g*8 +: 8])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pointer_select_q <= 1'b0;
    else if (sel_wr)
      pointer_select_q <= sfr_wdata[`XAE_PTR_SEL_BIT];
  end

  // Increment and immediate load act on the selected pointer only and
  // take priority over an SFR write to the same byte in that cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      first_data_pointer_q <= `XAE_RST_PTR;
    else if (!pointer_select_q && ptr_load)
      first_data_pointer_q <= ptr_load_value;
    else if (!pointer_select_q && ptr_inc)
      first_data_pointer_q <= first_data_pointer_q + 16'h0001;
    else if (ptr0_lo_wr)
      first_data_pointer_q[7:0] <= sfr_wdata;
    else if (ptr0_hi_wr)
      first_data_pointer_q[15:8] <= sfr_wdata;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      second_data_pointer_q <= `XAE_RST_PTR;
    else if (pointer_select_q && ptr_load)
      second_data_pointer_q <= ptr_load_value;
    else if (pointer_select_q && ptr_inc)
      second_data_pointer_q <= second_data_pointer_q + 16'h0001;
    else if (ptr1_lo_wr)
      second_data_pointer_q[7:0] <= sfr_wdata;
    else if (ptr1_hi_wr)
      second_data_pointer_q[15:8] <= sfr_wdata;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      first_pointer_extension_q <= `XAE_RST_BYTE;
      second_pointer_extension_q <= `XAE_RST_BYTE;
      index_upper_extension_q <= `XAE_RST_BYTE;
      index_middle_extension_q <= `XAE_RST_BYTE;
    end
    else
    begin
      if (ext0_wr)
        first_pointer_extension_q <= sfr_wdata;
      if (ext1_wr)
        second_pointer_extension_q <= sfr_wdata;
      if (idx_upper_wr)
        index_upper_extension_q <= sfr_wdata;
      if (idx_middle_wr)
        index_middle_extension_q <= sfr_wdata;
    end
  end

  // Code reads and indirect jumps use this 16-bit view only: the
  // extension bytes never reach it
  always_comb
  begin
    if (pointer_select_q)
      active_pointer_d = second_data_pointer_q;
    else
      active_pointer_d = first_data_pointer_q;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      active_pointer_q <= `XAE_RST_PTR;
    else
      active_pointer_q <= active_pointer_d;
  end

  always_comb
  begin
    if (xmove_via_index)
      xdata_addr_d = {index_upper_extension_q, index_middle_extension_q,
                      xmove_index};
    else if (pointer_select_q)
      xdata_addr_d = {second_pointer_extension_q,
                      second_data_pointer_q};
    else
      xdata_addr_d = {first_pointer_extension_q,
                      first_data_pointer_q};
  end

  // Address and region only change on an external-data move
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      xdata_addr_q <= `XAE_RST_ADDR;
      xdata_region_q <= XAE_REG_NONE;
    end
    else if (xmove_req)
    begin
      xdata_addr_q <= xdata_addr_d;
      xdata_region_q <= region_of(xdata_addr_d);
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      xdata_valid_q <= 1'b0;
    else
      xdata_valid_q <= xmove_req;
  end

  // Read mux; unmapped addresses read zero with no hit
  always_comb
  begin
    rdata_d = `XAE_RST_BYTE;
    hit_d = 1'b1;
    unique case (sfr_addr)
      `XAE_SFR_PTR0_LO: rdata_d = first_data_pointer_q[7:0];
      `XAE_SFR_PTR0_HI: rdata_d = first_data_pointer_q[15:8];
      `XAE_SFR_PTR1_LO: rdata_d = second_data_pointer_q[7:0];
      `XAE_SFR_PTR1_HI: rdata_d = second_data_pointer_q[15:8];
      `XAE_SFR_PTR_SEL: rdata_d = {7'h00, pointer_select_q};
      `XAE_SFR_PTR0_EXT: rdata_d = first_pointer_extension_q;
      `XAE_SFR_PTR1_EXT: rdata_d = second_pointer_extension_q;
      `XAE_SFR_IDX_UPPER: rdata_d = index_upper_extension_q;
      `XAE_SFR_IDX_MIDDLE: rdata_d = index_middle_extension_q;
      default:
      begin
        hit_d = 1'b0;
        for (int i = 0; i < NP; i++)
        begin
          if (sfr_addr == DATA_MAP[i*8 +: 8])
          begin
            rdata_d = port_data[i*8 +: 8];
            hit_d = 1'b1;
          end
          if (sfr_addr == SEL_MAP[i*8 +: 8])
          begin
            rdata_d = port_sel[i*8 +: 8];
            hit_d = 1'b1;
          end
          if (sfr_addr == STATE_MAP[i*8 +: 8])
          begin
            rdata_d = port_state[i*8 +: 8];
            hit_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sfr_rdata_q <= `XAE_RST_BYTE;
      sfr_hit_q <= 1'b0;
    end
    else if (sfr_rd_en)
    begin
      sfr_rdata_q <= rdata_d;
      sfr_hit_q <= hit_d;
    end
  end
endmodule : xae_sfr_ext
`default_nettype wire

/* File: xae_sfr_ext_asserts.sv */
`default_nettype none
module xae_sfr_ext_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sfr_wr_en,
  input wire logic ptr_inc,
  input wire logic ptr_load,
  input wire logic [15:0] active_pointer_q,
  input wire logic xmove_req,
  input wire logic xmove_via_index,
  input wire xae_pkg::xae_byte_type xmove_index,
  input wire logic [23:0] xdata_addr_q,
  input wire xae_pkg::xae_region_type xdata_region_q,
  input wire logic xdata_valid_q
);
  import xae_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_valid;
    xmove_req |=> xdata_valid_q;
  endproperty
  a_valid: assert property (p_valid)
    else $error("move gave no valid");
  property p_novalid;
    !xmove_req |=> !xdata_valid_q;
  endproperty
  a_novalid: assert property (p_novalid)
    else $error("valid without move");
  property p_hold;
    !xmove_req |=> $stable(xdata_addr_q) && $stable(xdata_region_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address changed without move");
  property p_idx;
    xmove_req && xmove_via_index
      |=> xdata_addr_q[7:0] == $past(xmove_index);
  endproperty
  a_idx: assert property (p_idx)
    else $error("low byte not index");
  property p_off;
    xdata_valid_q && xdata_addr_q[23]
      |-> xdata_region_q == XAE_REG_OFFCHIP;
  endproperty
  a_off: assert property (p_off)
    else $error("upper half not off-chip");
  property p_sram;
    xdata_valid_q && xdata_addr_q < 24'h00_2000
      |-> xdata_region_q == XAE_REG_SRAM;
  endproperty
  a_sram: assert property (p_sram)
    else $error("low window not static RAM");
  property p_ecc;
    xdata_valid_q && xdata_addr_q inside {[24'h08_0000:24'h08_1FFF]}
      |-> xdata_region_q == XAE_REG_ECC;
  endproperty
  a_ecc: assert property (p_ecc)
    else $error("window not ECC");
  // Idle cycle first, so the lagging copy shows exactly one step
  property p_inc;
    !ptr_inc && !ptr_load && !sfr_wr_en ##1 ptr_inc && !ptr_load
      && !sfr_wr_en |=> ##1
      active_pointer_q == 16'($past(active_pointer_q) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc)
    else $error("pointer increment wrong");
endmodule : xae_sfr_ext_asserts
bind xae_sfr_ext xae_sfr_ext_asserts i_chk (.ref_clk, .reset, .sfr_wr_en,
  .ptr_inc, .ptr_load, .active_pointer_q, .xmove_req, .xmove_via_index,
  .xmove_index, .xdata_addr_q, .xdata_region_q, .xdata_valid_q);
`default_nettype wire

/* File: xae_core_model.sv */
`default_nettype none
module xae_core_model (
  input wire logic ref_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr_en,
  output logic sfr_rd_en,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  output logic ptr_inc,
  output logic ptr_load,
  output logic [15:0] ptr_load_value,
  output logic xmove_req,
  output logic xmove_via_index,
  output logic [7:0] xmove_index
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {sfr_addr, sfr_wr_en, sfr_rd_en, sfr_wdata} = '0;
    {ptr_inc, ptr_load, ptr_load_value} = '0;
    {xmove_req, xmove_via_index, xmove_index} = '0;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {sfr_addr, sfr_wdata, sfr_wr_en} <= {a, d, 1'b1};
    @(posedge ref_clk);
    {sfr_addr, sfr_wdata, sfr_wr_en} <= {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    {sfr_addr, sfr_rd_en} <= {a, 1'b1};
    @(posedge ref_clk);
    {sfr_addr, sfr_rd_en} <= {~a, 1'b0};
    #1;
    d = sfr_rdata_q;
  endtask : rd
  task automatic pt(input logic i, input logic l, input logic [15:0] v);
    @(posedge ref_clk);
    {ptr_inc, ptr_load, ptr_load_value} <= {i, l, v};
    @(posedge ref_clk);
    {ptr_inc, ptr_load, ptr_load_value} <= {2'b00, ~v};
    #1;
  endtask : pt
  task automatic mv(input logic via, input logic [7:0] i);
    @(posedge ref_clk);
    {xmove_req, xmove_via_index, xmove_index} <= {1'b1, via, i};
    @(posedge ref_clk);
    {xmove_req, xmove_index} <= {1'b0, ~i};
    #1;
  endtask : mv
endmodule : xae_core_model
`default_nettype wire

/* File: xae_sfr_ext_tb.sv */
`include "xae_cfg.svh"
`default_nettype none
module xae_sfr_ext_tb;
  import xae_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic sfr_wr_en, sfr_rd_en, sfr_hit_q, ptr_inc, ptr_load;
  logic xmove_req, xmove_via_index, xdata_valid_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, xmove_index;
  logic [15:0] ptr_load_value, active_pointer_q;
  logic [23:0] xdata_addr_q;
  xae_region_type xdata_region_q;
  logic [71:0] hub_port_output_data = '0;
  logic [71:0] pin_level = '0;
  logic [71:0] port_pin_out_q;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  xae_sfr_ext i_dut (.ref_clk, .reset, .sfr_addr, .sfr_wr_en, .sfr_rd_en,
    .sfr_wdata, .sfr_rdata_q, .sfr_hit_q, .ptr_inc, .ptr_load,
    .ptr_load_value, .active_pointer_q, .xmove_req, .xmove_via_index,
    .xmove_index, .xdata_addr_q, .xdata_region_q, .xdata_valid_q,
    .hub_port_output_data, .pin_level, .port_pin_out_q);
  xae_core_model i_core (.ref_clk, .sfr_addr, .sfr_wr_en, .sfr_rd_en,
    .sfr_wdata, .sfr_rdata_q, .ptr_inc, .ptr_load, .ptr_load_value,
    .xmove_req, .xmove_via_index, .xmove_index);
  task automatic chk(input logic [23:0] s, input logic [23:0] e,
    input string m);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s seen %h wanted %h", $time, m, s, e);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic rc(input logic [7:0] a, input logic [7:0] e,
    input logic h);
    logic [7:0] v;
    i_core.rd(a, v);
    chk(v, e, "read data");
    chk(sfr_hit_q, h, "read hit");
  endtask : rc
  task automatic mc(input logic via, input logic [7:0] i,
    input logic [23:0] a, input xae_region_type r);
    i_core.mv(via, i);
    chk(xdata_valid_q, 1'b1, "valid");
    chk(xdata_addr_q, a, "address");
    chk(xdata_region_q, r, "region");
  endtask : mc
  task automatic t_regs();
    logic [7:0] a [9] = '{8'h93, 8'h95, 8'hEA, 8'hA0, 8'h82, 8'h83,
      8'h84, 8'h85, 8'h86};
    logic [7:0] d;
    for (int i = 0; i < 9; i++)
    begin
      d = (i == 8) ? 8'h01 : 8'hA5 ^ 8'(i);
      rc(a[i], 8'h00, 1'b1);
      i_core.wr(a[i], d);
      rc(a[i], d, 1'b1);
    end
    i_core.wr(8'h81, 8'hFF);
    rc(8'h81, 8'h00, 1'b0);
  endtask : t_regs
  task automatic t_moves();
    i_core.wr(8'h86, 8'h00);
    i_core.wr(8'h82, 8'h56);
    i_core.wr(8'h83, 8'h34);
    i_core.wr(8'h93, 8'hAB);
    mc(1'b0, 8'hFF, 24'hAB_3456, XAE_REG_OFFCHIP);
    i_core.wr(8'h86, 8'h01);
    i_core.wr(8'h84, 8'h34);
    i_core.wr(8'h85, 8'h12);
    i_core.wr(8'h95, 8'h00);
    mc(1'b0, 8'h00, 24'h00_1234, XAE_REG_SRAM);
    chk(active_pointer_q, 16'h1234, "pointer");
  endtask : t_moves
  task automatic t_idx();
    logic [23:0] a [11] = '{24'h00_1FFF, 24'h00_2000, 24'h00_51FF,
      24'h00_5400, 24'h00_7FFF, 24'h00_8FFF, 24'h01_0000, 24'h08_0000,
      24'h08_2000, 24'h7F_FFFF, 24'h80_0000};
    xae_region_type r [11] = '{XAE_REG_SRAM, XAE_REG_OTHER,
      XAE_REG_IOPORT, XAE_REG_EMIFCTL, XAE_REG_HUBCFG, XAE_REG_NVDATA,
      XAE_REG_INTERCON, XAE_REG_ECC, XAE_REG_OTHER, XAE_REG_OTHER,
      XAE_REG_OFFCHIP};
    for (int i = 0; i < 11; i++)
    begin
      i_core.wr(8'hEA, a[i][23:16]);
      i_core.wr(8'hA0, a[i][15:8]);
      mc(1'b1, a[i][7:0], a[i], r[i]);
    end
  endtask : t_idx
  task automatic t_ptr();
    i_core.wr(8'h86, 8'h00);
    i_core.pt(1'b0, 1'b1, 16'hFFFF);
    i_core.pt(1'b1, 1'b0, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk(active_pointer_q, 16'h0000, "wrapped increment");
    i_core.pt(1'b1, 1'b1, 16'h0100);
    @(posedge ref_clk);
    #1;
    chk(active_pointer_q, 16'h0100, "load over increment");
    i_core.wr(8'h86, 8'h01);
    @(posedge ref_clk);
    #1;
    chk(active_pointer_q, 16'h1234, "second pointer kept");
  endtask : t_ptr
  task automatic t_ports();
    logic [7:0] da, sa, ta;
    for (int i = 0; i < 9; i++)
    begin
      da = 8'(`XAE_SFR_DATA_MAP >> (8 * i));
      sa = 8'(`XAE_SFR_SEL_MAP >> (8 * i));
      ta = 8'(`XAE_SFR_STATE_MAP >> (8 * i));
      @(posedge ref_clk);
      hub_port_output_data[8*i+:8] <= 8'hC3;
      pin_level[8*i+:8] <= 8'h96 ^ 8'(i);
      i_core.wr(da, 8'h5A);
      i_core.wr(sa, 8'h0F);
      i_core.wr(ta, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(port_pin_out_q[8*i+:8], 8'hCA, "pin drive");
      rc(ta, 8'h96 ^ 8'(i), 1'b1);
    end
  endtask : t_ports
  // Mid-run reset: region, valid, pointer, pins and pointer select back to reset values, index extensions too
  task automatic t_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk(xdata_region_q, XAE_REG_NONE, "region after reset");
    chk(xdata_valid_q, 1'b0, "valid after reset");
    chk(active_pointer_q, 16'h0000, "pointer after reset");
    chk({23'h00_0000, |port_pin_out_q}, 24'h00_0000, "pins reset");
    rc(8'h86, 8'h00, 1'b1);
    mc(1'b1, 8'h00, 24'h00_0000, XAE_REG_SRAM);
  endtask : t_reset
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_moves();
    t_idx();
    t_ptr();
    t_ports();
    t_reset();
    tally_and_finish();
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
endmodule : xae_sfr_ext_tb
`default_nettype wire
